// ---- verilog/tww_pkg.sv ----
// package of the timer, watchdog and wake-up control block
// assumes a 200 MHz sys_clk and a plain register port with 5-bit addresses
package tww_pkg;

   // ***********************
   // timing
   // ***********************
   localparam int CLK_PERIOD_NS = 5;
   localparam int WDT_LONG_NS = 18_000_000;
   localparam int WDT_SHORT_NS = 4_500_000;
   localparam int WDT_STEPS = 256;
   localparam int WDT_LONG_TICK = WDT_LONG_NS / CLK_PERIOD_NS / WDT_STEPS;
   localparam int WDT_SHORT_TICK = WDT_SHORT_NS / CLK_PERIOD_NS / WDT_STEPS;

   // ***********************
   // register offsets
   // ***********************
   localparam logic [4:0] ADDR_TIMER_COUNTER = 5'h01;
   localparam logic [4:0] ADDR_TIMER_CONTROL = 5'h02;
   localparam logic [4:0] ADDR_WATCHDOG_CONTROL = 5'h0E;
   localparam logic [4:0] ADDR_INTERRUPT_FLAGS = 5'h0F;
   localparam logic [4:0] ADDR_WAKEUP_CONTROL = 5'h1D;
   localparam logic [4:0] ADDR_OPTION_CONTROL = 5'h1E;
   localparam logic [4:0] ADDR_INTERRUPT_MASK = 5'h1F;

   // ***********************
   // field positions
   // ***********************
   localparam int WDC_ENABLE_BIT = 7;
   localparam int WDC_PRESCALE_BIT = 3;
   localparam int TMC_IRQ_FLAG_BIT = 6;
   localparam int TMC_SOURCE_BIT = 5;
   localparam int TMC_EDGE_BIT = 4;
   localparam int TMC_PRESCALE_BIT = 3;
   localparam int WKC_ADC_BIT = 2;
   localparam int WKC_CMP_BIT = 1;
   localparam int WKC_PORT_BIT = 0;
   localparam int IRQ_CMP_BIT = 7;
   localparam int IRQ_ADC_BIT = 3;
   localparam int IRQ_PORT_BIT = 1;
   localparam int IRQ_TIMER_BIT = 0;
   localparam int OPT_PERIOD_BIT = 0;

   // ***********************
   // masks and reset values
   // ***********************
   localparam logic [7:0] WDC_RW_MASK = 8'h8F;
   localparam logic [7:0] WKC_RW_MASK = 8'h07;
   localparam logic [7:0] TMC_RW_MASK = 8'hBF;
   localparam logic [7:0] IRQ_USED_MASK = 8'h8B;
   localparam logic [7:0] WDC_RESET = 8'h00;
   localparam logic [7:0] WKC_RESET = 8'h00;
   localparam logic [7:0] TMC_RESET = 8'h00;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   localparam logic [7:0] OPT_RESET = 8'h01;
   localparam logic [7:0] PORT_CHANGE_VECTOR = 8'h06;

   // ***********************
   // carriers
   // ***********************
   typedef struct packed {
      logic wdt_clear;
      logic sleep;
      logic irq_on;
      logic irq_off;
   } tww_instr_s;

   typedef struct packed {
      logic adc_done;
      logic adc_busy;
      logic cmp_change;
      logic port_change;
   } tww_events_s;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tww_bus_s;

endpackage

// ---- verilog/tww_timer_watchdog.sv ----
// timer/counter, watchdog, both prescalers and sleep wake-up control
// assumes instruction and event pulses come from core logic on sys_clk;
// the timer pin is asynchronous and is synchronised here
//
// Function
// - watchdog control bit 7 enables the watchdog, read and write
// - watchdog prescale enable off gives 1:1, on uses the ratio field
// - watchdog ratio codes 000 to 111 give 1:2 up to 1:256, doubling
// - unused watchdog control bits 6-4 and wake-up bits 7-3 read zero
// - wake-up bit 2 lets adc completion wake the device from sleep
// - wake-up bit 1 lets a comparator output change wake the device
// - wake-up bit 0 lets a port 5 input change wake the device
// - separate 8-bit prescaler counters for the timer and the watchdog
// - any write to the timer counter clears the timer prescaler
// - watchdog-clear and sleep instructions clear watchdog and its prescaler
// - 8-bit timer counts every main clock on internal source, no prescaler
// - external source counts selected rising or falling pin edges, 1:1 or through the timer prescaler
// - internally clocked timer stops while sleeping
// - sleep entered during adc conversion with adc wake keeps timer running
// - watchdog runs from its own free tick and keeps counting in sleep
// - enabled watchdog time-out resets the device, awake or asleep
// - software may enable or disable the watchdog at any time
// - unprescaled time-out is about 18 ms or about 4.5 ms
// - port change wake or interrupt vectors to 006H if irqs on and interrupt mask bit 1 set; a wake with irqs off resumes
// - period option bit 1 selects 18 ms (default), 0 selects 4.5 ms
//
// The address-and-strobe port was chosen for this implementation.
module tww_timer_watchdog
   import tww_pkg::*;
#(
   parameter int WDT_LONG_CYC = WDT_LONG_TICK,
   parameter int WDT_SHORT_CYC = WDT_SHORT_TICK
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tww_bus_s bus,
   output logic [7:0] rdata,
   input wire tww_instr_s instr,
   input wire tww_events_s events,
   input wire logic timer_pin,
   output logic sleeping,
   output logic wake,
   output logic wdt_reset,
   output logic vector_take,
   output logic [7:0] vector_addr,
   output logic resume_next,
   output logic irq_enabled
);

   // ***********************
   // prescaler ratio decode
   // ***********************
   // true when the count has reached the end of a 1:2..1:256 period
   function automatic logic ratio_hit(input logic [7:0] cnt, input logic [2:0] code);
      logic [7:0] lim;
      lim = 8'hFF >> (3'h7 - code);
      return (cnt & lim) == lim;
   endfunction

   // ***********************
   // write decode
   // ***********************
   // true when the bus writes the given register this cycle
   function automatic logic wr_to(input tww_bus_s b, input logic [4:0] a);
      return b.wr && b.addr == a;
   endfunction

   // ***********************
   // registers
   // ***********************
   logic [7:0] wdc_q;
   logic [7:0] wkc_q;
   logic [7:0] tmc_q;
   logic [7:0] irq_flag_q;
   logic [7:0] irq_mask_q;
   logic [7:0] opt_q;
   logic [7:0] tcnt_q;
   logic [7:0] tpre_q;
   logic [7:0] wpre_q;
   logic [7:0] wcnt_q;
   logic [13:0] wtick_q;
   logic [7:0] rdata_q;
   logic gie_q;
   logic sleep_q;
   logic keep_run_q;
   logic [2:0] pin_sync_q;
   logic pin_lvl_q;
   logic wdt_reset_q;
   logic vector_q;
   logic resume_q;

   logic wr_tcnt;
   logic pin_stable;
   logic pin_edge;
   logic ext_step;
   logic tim_step;
   logic tcnt_wrap;
   logic wdt_tick;
   logic wdt_step;
   logic wdt_clr;
   logic wdt_timeout;
   logic [13:0] wtick_lim;
   logic wake_now;
   logic port_irq;
   logic wr_flags;
   logic [7:0] irq_set;
   logic [7:0] irq_keep;

   assign wr_tcnt = wr_to(bus, ADDR_TIMER_COUNTER);
   assign wr_flags = wr_to(bus, ADDR_INTERRUPT_FLAGS);

   // ***********************
   // register writes
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wdc_q <= WDC_RESET;
         wkc_q <= WKC_RESET;
         tmc_q <= TMC_RESET;
         irq_mask_q <= IRQ_RESET;
         opt_q <= OPT_RESET;
      end else if (bus.wr) begin
         unique case (bus.addr)
            ADDR_WATCHDOG_CONTROL: wdc_q <= bus.wdata & WDC_RW_MASK;
            ADDR_WAKEUP_CONTROL: wkc_q <= bus.wdata & WKC_RW_MASK;
            ADDR_TIMER_CONTROL: tmc_q <= bus.wdata & TMC_RW_MASK;
            ADDR_INTERRUPT_MASK: irq_mask_q <= bus.wdata & IRQ_USED_MASK;
            ADDR_OPTION_CONTROL: opt_q <= bus.wdata & 8'h01;
            default: ;
         endcase
      end
   end

   // ***********************
   // read port
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         unique case (bus.addr)
            ADDR_TIMER_COUNTER: rdata_q <= tcnt_q;
            ADDR_TIMER_CONTROL: rdata_q <= tmc_q | {1'b0, gie_q, 6'h00};
            ADDR_WATCHDOG_CONTROL: rdata_q <= wdc_q;
            ADDR_INTERRUPT_FLAGS: rdata_q <= irq_flag_q;
            ADDR_WAKEUP_CONTROL: rdata_q <= wkc_q;
            ADDR_OPTION_CONTROL: rdata_q <= opt_q;
            ADDR_INTERRUPT_MASK: rdata_q <= irq_mask_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata = rdata_q;

   // ***********************
   // global interrupt enable
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gie_q <= 1'b0;
      end else if (instr.irq_on) begin
         gie_q <= 1'b1;
      end else if (instr.irq_off) begin
         gie_q <= 1'b0;
      end
   end

   // ***********************
   // sleep state
   // ***********************
   assign wake_now = sleep_q && ((events.adc_done && wkc_q[WKC_ADC_BIT])
      || (events.cmp_change && wkc_q[WKC_CMP_BIT])
      || (events.port_change && wkc_q[WKC_PORT_BIT]));

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sleep_q <= 1'b0;
         keep_run_q <= 1'b0;
      end else if (wake_now || wdt_timeout) begin
         sleep_q <= 1'b0;
         keep_run_q <= 1'b0;
      end else if (instr.sleep) begin
         sleep_q <= 1'b1;
         keep_run_q <= events.adc_busy && wkc_q[WKC_ADC_BIT];
      end
   end

   // ***********************
   // timer pin synchroniser
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_sync_q <= 3'h0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], timer_pin};
      end
   end

   assign pin_stable = pin_sync_q[1] == pin_sync_q[2];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pin_lvl_q <= 1'b0;
      end else if (pin_stable) begin
         pin_lvl_q <= pin_sync_q[2];
      end
   end

   // edge select 0 counts rising, 1 counts falling
   assign pin_edge = pin_stable && pin_sync_q[2] != pin_lvl_q
      && pin_sync_q[2] == !tmc_q[TMC_EDGE_BIT];

   // ***********************
   // timer prescaler and counter
   // ***********************
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tpre_q <= 8'h00;
      end else if (wr_tcnt || !tmc_q[TMC_SOURCE_BIT]) begin
         tpre_q <= 8'h00;
      end else if (pin_edge && tmc_q[TMC_PRESCALE_BIT]) begin
         tpre_q <= ratio_hit(tpre_q, tmc_q[2:0]) ? 8'h00 : tpre_q + 8'h01;
      end
   end

   assign ext_step = pin_edge && (!tmc_q[TMC_PRESCALE_BIT] || ratio_hit(tpre_q, tmc_q[2:0]));
   assign tim_step = tmc_q[TMC_SOURCE_BIT] ? ext_step
      : (!sleep_q || keep_run_q);
   assign tcnt_wrap = tim_step && tcnt_q == 8'hFF;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tcnt_q <= 8'h00;
      end else if (wr_tcnt) begin
         tcnt_q <= bus.wdata;
      end else if (tim_step) begin
         tcnt_q <= tcnt_q + 8'h01;
      end
   end

   // ***********************
   // interrupt flags
   // ***********************
   // software writes 0 to clear a flag; a same-cycle event keeps it set
   always_comb begin
      irq_set = 8'h00;
      irq_set[IRQ_CMP_BIT] = events.cmp_change;
      irq_set[IRQ_ADC_BIT] = events.adc_done;
      irq_set[IRQ_PORT_BIT] = events.port_change;
      irq_set[IRQ_TIMER_BIT] = tcnt_wrap && !wr_tcnt;
      irq_keep = wr_flags ? irq_flag_q & bus.wdata : irq_flag_q;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq_flag_q <= IRQ_RESET;
      end else begin
         irq_flag_q <= irq_keep | irq_set;
      end
   end

   // ***********************
   // watchdog tick, prescaler and counter
   // ***********************
   assign wtick_lim = opt_q[OPT_PERIOD_BIT] ? 14'(WDT_LONG_CYC - 1) : 14'(WDT_SHORT_CYC - 1);
   assign wdt_tick = wtick_q >= wtick_lim;
   assign wdt_clr = instr.wdt_clear || instr.sleep || !wdc_q[WDC_ENABLE_BIT];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wtick_q <= 14'h0000;
      end else if (wdt_tick) begin
         wtick_q <= 14'h0000;
      end else begin
         wtick_q <= wtick_q + 14'h0001;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wpre_q <= 8'h00;
      end else if (wdt_clr || !wdc_q[WDC_PRESCALE_BIT]) begin
         wpre_q <= 8'h00;
      end else if (wdt_tick) begin
         wpre_q <= ratio_hit(wpre_q, wdc_q[2:0]) ? 8'h00 : wpre_q + 8'h01;
      end
   end

   assign wdt_step = wdt_tick && (!wdc_q[WDC_PRESCALE_BIT] || ratio_hit(wpre_q, wdc_q[2:0]));
   assign wdt_timeout = !wdt_clr && wdt_step && wcnt_q == 8'hFF;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wcnt_q <= 8'h00;
      end else if (wdt_clr) begin
         wcnt_q <= 8'h00;
      end else if (wdt_step) begin
         wcnt_q <= wcnt_q + 8'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wdt_reset_q <= 1'b0;
      end else begin
         wdt_reset_q <= wdt_timeout;
      end
   end

   // ***********************
   // wake and vector outputs
   // ***********************
   assign port_irq = events.port_change && irq_mask_q[IRQ_PORT_BIT]
      && (!sleep_q || wkc_q[WKC_PORT_BIT]);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         vector_q <= 1'b0;
         resume_q <= 1'b0;
      end else begin
         vector_q <= port_irq && gie_q;
         resume_q <= wake_now && !gie_q;
      end
   end

   assign sleeping = sleep_q;
   assign wake = wake_now;
   assign wdt_reset = wdt_reset_q;
   assign vector_take = vector_q;
   assign vector_addr = PORT_CHANGE_VECTOR;
   assign resume_next = resume_q;
   assign irq_enabled = gie_q;

endmodule

// ---- test/tww_assertions.sv ----
// port checks for the timer, watchdog and wake-up block
// assumes one clock domain, reset active high
module tww_checker
   import tww_pkg::*;
#(
   parameter int WDT_LONG_CYC = 4,
   parameter int WDT_SHORT_CYC = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tww_bus_s bus,
   input wire logic [7:0] rdata,
   input wire tww_instr_s instr,
   input wire tww_events_s events,
   input wire logic timer_pin,
   input wire logic sleeping,
   input wire logic wake,
   input wire logic wdt_reset,
   input wire logic vector_take,
   input wire logic [7:0] vector_addr,
   input wire logic resume_next,
   input wire logic irq_enabled
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_wdc_rsvd;
      $past(bus.rd) && $past(bus.addr) == ADDR_WATCHDOG_CONTROL |-> (rdata & ~WDC_RW_MASK) == 8'h00;
   endproperty
   a_wdc_rsvd: assert property (p_wdc_rsvd) else $error("watchdog control spare bits set");
   property p_wkc_rsvd;
      $past(bus.rd) && $past(bus.addr) == ADDR_WAKEUP_CONTROL |-> (rdata & ~WKC_RW_MASK) == 8'h00;
   endproperty
   a_wkc_rsvd: assert property (p_wkc_rsvd) else $error("wake control spare bits set");
   property p_wake_cause;
      wake |-> sleeping && (events.adc_done || events.cmp_change || events.port_change);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake without event");
   property p_resume;
      wake && !irq_enabled |=> resume_next && !sleeping;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume after wake");
   property p_vector;
      vector_take |-> $past(irq_enabled) && $past(events.port_change) && vector_addr == 8'h06;
   endproperty
   a_vector: assert property (p_vector) else $error("bad vector");
   property p_irq_on;
      instr.irq_on |=> irq_enabled;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq enable missed");
   property p_wdt_once;
      wdt_reset |=> !wdt_reset [*8];
   endproperty
   a_wdt_once: assert property (p_wdt_once) else $error("watchdog pulse too long");
   property p_wdt_clr;
      instr.wdt_clear || instr.sleep |-> ##2 !wdt_reset [*8];
   endproperty
   a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");
   property p_wdt_wake;
      wdt_reset |-> ##[0:1] !sleeping;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("sleep kept after time-out");
   c_wake: cover property (wake);
   c_wdt: cover property (wdt_reset);
   c_vec: cover property (vector_take);
endmodule
bind tww_timer_watchdog tww_checker #(.WDT_LONG_CYC(WDT_LONG_CYC), .WDT_SHORT_CYC(WDT_SHORT_CYC)) i_tww_checker (
   .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .instr(instr), .events(events), .timer_pin(timer_pin),
   .sleeping(sleeping), .wake(wake), .wdt_reset(wdt_reset), .vector_take(vector_take), .vector_addr(vector_addr),
   .resume_next(resume_next), .irq_enabled(irq_enabled));

// ---- test/tww_pin_model.sv ----
// external timer clock source
// assumes the pin idles low between bursts
module tww_pin_model (
   input wire logic sys_clk,
   output logic timer_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial timer_pin = 1'b0;
   task pulses(input int n, input int hold);
      repeat (n) begin
         repeat (hold) @(posedge sys_clk);
         timer_pin <= 1'b1;
         repeat (hold) @(posedge sys_clk);
         timer_pin <= 1'b0;
      end
   endtask
endmodule

// ---- test/tb_top.sv ----
// testbench for the timer, watchdog and wake-up block
// assumes short watchdog ticks and the pin model on timer_pin
module tb_top
   import tww_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0;
   logic rst = 1;
   tww_bus_s bus = '0;
   tww_instr_s instr = '0;
   tww_events_s events = '0;
   logic timer_pin;
   logic [7:0] rdata, vector_addr, r;
   logic sleeping, wake, wdt_reset, vector_take, resume_next, irq_enabled;
   int fail_count = 0;
   int check_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   tww_timer_watchdog #(.WDT_LONG_CYC(4), .WDT_SHORT_CYC(2)) i_tww_timer_watchdog (.sys_clk(sys_clk), .rst(rst),
      .bus(bus), .rdata(rdata), .instr(instr), .events(events), .timer_pin(timer_pin), .sleeping(sleeping),
      .wake(wake), .wdt_reset(wdt_reset), .vector_take(vector_take), .vector_addr(vector_addr),
      .resume_next(resume_next), .irq_enabled(irq_enabled));
   tww_pin_model i_tww_pin_model (.sys_clk(sys_clk), .timer_pin(timer_pin));
   // *****
   // shared tasks
   // *****
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask
   task rd(input logic [4:0] a);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 r = rdata;
   endtask
   task ins(input logic [3:0] v);
      @(posedge sys_clk);
      instr <= tww_instr_s'(v);
      @(posedge sys_clk);
      instr <= '0;
   endtask
   task ev(input logic [3:0] e, input logic [7:0] exp);
      @(posedge sys_clk);
      events <= tww_events_s'(e);
      #1 chk(8'(wake), exp);
      @(posedge sys_clk);
      events <= tww_events_s'(e & 4'h4);
   endtask
   task wdt_wait(input int cyc);
      int n;
      n = 0;
      while (wdt_reset !== 1'b1 && n < cyc + 40) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk(8'(n >= cyc - 12 && n <= cyc + 12), 8'h01);
   endtask
   // *****
   // scenarios
   // *****
   task t_regs();
      rd(ADDR_OPTION_CONTROL);
      chk(r, 8'h01);
      wr(ADDR_WATCHDOG_CONTROL, 8'h7F);
      rd(ADDR_WATCHDOG_CONTROL);
      chk(r, 8'h0F);
      wr(ADDR_WATCHDOG_CONTROL, 8'h80);
      rd(ADDR_WATCHDOG_CONTROL);
      chk(r, 8'h80);
      wr(ADDR_WATCHDOG_CONTROL, 8'h00);
      wr(ADDR_WAKEUP_CONTROL, 8'hFF);
      rd(ADDR_WAKEUP_CONTROL);
      chk(r, 8'h07);
      rd(5'h1C);
      chk(r, 8'h00);
   endtask
   task t_timer();
      wr(ADDR_TIMER_CONTROL, 8'h00);
      wr(ADDR_INTERRUPT_FLAGS, 8'h00);
      wr(ADDR_TIMER_COUNTER, 8'hFE);
      rd(ADDR_TIMER_COUNTER);
      chk(r, 8'hFF);
      repeat (3) @(posedge sys_clk);
      rd(ADDR_INTERRUPT_FLAGS);
      chk(r & 8'h01, 8'h01);
   endtask
   task t_pin();
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_TIMER_CONTROL, i == 0 ? 8'h20 : 8'h30);
         wr(ADDR_TIMER_COUNTER, 8'h00);
         i_tww_pin_model.pulses(5 - 2 * i, 4);
         repeat (6) @(posedge sys_clk);
         rd(ADDR_TIMER_COUNTER);
         chk(r, 8'(5 - 2 * i));
      end
      wr(ADDR_TIMER_CONTROL, 8'h28);
      i_tww_pin_model.pulses(1, 4);
      repeat (6) @(posedge sys_clk);
      wr(ADDR_TIMER_COUNTER, 8'h00);
      i_tww_pin_model.pulses(1, 4);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_TIMER_COUNTER);
      chk(r, 8'h00);
      i_tww_pin_model.pulses(1, 4);
      repeat (6) @(posedge sys_clk);
      rd(ADDR_TIMER_COUNTER);
      chk(r, 8'h01);
   endtask
   task t_sleep();
      wr(ADDR_WATCHDOG_CONTROL, 8'h00);
      wr(ADDR_TIMER_CONTROL, 8'h00);
      wr(ADDR_WAKEUP_CONTROL, 8'h01);
      ins(4'b0100);
      #1 chk(8'(sleeping), 8'h01);
      wr(ADDR_TIMER_COUNTER, 8'h40);
      repeat (10) @(posedge sys_clk);
      rd(ADDR_TIMER_COUNTER);
      chk(r, 8'h40);
      ev(4'h1, 8'h01);
      #1 chk(8'(resume_next), 8'h01);
      chk(8'(sleeping), 8'h00);
      wr(ADDR_WAKEUP_CONTROL, 8'h02);
      ins(4'b0100);
      ev(4'h1, 8'h00);
      ev(4'h2, 8'h01);
      ins(4'b0010);
      #1 chk(8'(irq_enabled), 8'h01);
      wr(ADDR_INTERRUPT_MASK, 8'h02);
      wr(ADDR_WAKEUP_CONTROL, 8'h01);
      ins(4'b0100);
      ev(4'h1, 8'h01);
      #1 chk(8'(vector_take), 8'h01);
      chk(vector_addr, PORT_CHANGE_VECTOR);
      wr(ADDR_WAKEUP_CONTROL, 8'h04);
      ev(4'h4, 8'h00);
      ins(4'b0100);
      wr(ADDR_TIMER_COUNTER, 8'h20);
      repeat (10) @(posedge sys_clk);
      rd(ADDR_TIMER_COUNTER);
      chk(8'(r != 8'h20), 8'h01);
      ev(4'hC, 8'h01);
      @(posedge sys_clk);
      events <= '0;
   endtask
   task t_wdt();
      logic [7:0] opt [4] = '{8'h00, 8'h00, 8'h00, 8'h01};
      logic [7:0] wdc [4] = '{8'h80, 8'h88, 8'h89, 8'h80};
      int cyc [4] = '{512, 1024, 2048, 1024};
      wr(ADDR_OPTION_CONTROL, 8'h00);
      wr(ADDR_WATCHDOG_CONTROL, 8'h80);
      repeat (300) @(posedge sys_clk);
      ins(4'b1000);
      wdt_wait(512);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_WATCHDOG_CONTROL, 8'h00);
         wr(ADDR_OPTION_CONTROL, opt[i]);
         wr(ADDR_WATCHDOG_CONTROL, wdc[i]);
         wdt_wait(cyc[i]);
      end
      wr(ADDR_WATCHDOG_CONTROL, 8'h00);
   endtask
   task final_report();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs();
      t_timer();
      t_pin();
      t_sleep();
      t_wdt();
      final_report();
   end
   initial begin
      #100us;
      fail_count++;
      final_report();
   end
endmodule
